// File: include/ddri_params.svh
/*
 Timing counts, command encodings and mode-register field positions for the
 power-up sequencer. Assumes a 100 MHz controller clock.
*/
`ifndef DDRI_PARAMS_SVH
`define DDRI_PARAMS_SVH
`define DDRI_CLK_PERIOD_NS 10
`define DDRI_T_STABLE_US 200
`define DDRI_T_STABLE_CYC ((`DDRI_T_STABLE_US * 1000 + `DDRI_CLK_PERIOD_NS - 1) / `DDRI_CLK_PERIOD_NS)
`define DDRI_T_CKE_NS 400
`define DDRI_T_CKE_CYC ((`DDRI_T_CKE_NS + `DDRI_CLK_PERIOD_NS - 1) / `DDRI_CLK_PERIOD_NS)
`define DDRI_DLL_LOCK_CYC 200
`define DDRI_GAP_CYC 4
`define DDRI_REFRESH_COUNT 2
`define DDRI_ADDR_DLL_RESET 8
`define DDRI_ADDR_AUTO_PRE 10
`define DDRI_ADDR_DLL_OFF 0
`define DDRI_ADDR_STROBE_SE 10
`define DDRI_ADDR_RD_STROBE 11
`define DDRI_ADDR_DRV_LSB 7
`define DDRI_ADDR_DRV_MSB 9
`define DDRI_BANK_EMR2 3'h2
`define DDRI_BANK_EMR3 3'h3
`define DDRI_BANK_EMR1 3'h1
`define DDRI_BANK_MR 3'h0
`define DDRI_CMD_NOP 4'h7
`define DDRI_CMD_DESEL 4'hF
`define DDRI_CMD_PRE 4'h2
`define DDRI_CMD_MODE 4'h0
`define DDRI_CMD_REF 4'h1
`define DDRI_CMD_ACT 4'h3
`define DDRI_CMD_RD 4'h5
`define DDRI_CMD_WR 4'h4
`endif

// File: include/ddri_pkg.sv
/*
 Types shared by the power-up sequencer files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ddri_pkg;
   typedef enum logic [1:0] {DDRI_OP_ACT, DDRI_OP_RD, DDRI_OP_WR, DDRI_OP_PRE} ddri_op_t;
endpackage

// File: src/ddri_init_ctrl.sv
/*
 Controller that powers up and initializes an external DDR2 memory, then
 passes single activate/read/write/precharge orders to it.
 Assumes the memory clock pair is generated outside from clk and that power
 is stable when rst_n is released.
*/
`timescale 1ns/100ps
`include "ddri_params.svh"
module ddri_init_ctrl
   import ddri_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int BANK_W = 3,
   parameter int T_STABLE_CYC = `DDRI_T_STABLE_CYC,
   parameter logic [ADDR_W-1:0] MODE_OPS = 16'h0032,
   parameter logic [ADDR_W-1:0] EXT1_OPS = 16'h0000
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   output logic req_ready,
   input wire ddri_op_t req_op,
   input wire logic [BANK_W-1:0] req_bank,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic req_auto_pre,
   output logic init_done,
   output logic mem_ck_en,
   output logic die_term_ctl,
   output logic mem_cs_n,
   output logic mem_ras_n,
   output logic mem_cas_n,
   output logic mem_we_n,
   output logic bank_sel_0,
   output logic bank_sel_1,
   output logic bank_sel_2,
   output logic [ADDR_W-1:0] mem_addr
);

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      DDRI_S_POWER, DDRI_S_CKE, DDRI_S_PRE1, DDRI_S_EMR2, DDRI_S_EMR3, DDRI_S_EMR1,
      DDRI_S_MRRST, DDRI_S_PRE2, DDRI_S_REF, DDRI_S_MROP, DDRI_S_DRVDEF, DDRI_S_DRVEXIT,
      DDRI_S_READY
   } ddri_state_t;

   ddri_state_t state_q;
   logic timer_load;
   logic [31:0] timer_val;
   logic timer_done;
   logic started_q;
   logic [1:0] ref_cnt_q;
   logic [7:0] lock_cnt_q;
   logic issue;
   logic [3:0] cmd_d;
   logic [BANK_W-1:0] bank_d;
   logic [ADDR_W-1:0] addr_d;
   logic [3:0] cmd_q;
   logic [BANK_W-1:0] bank_q;
   logic [(1 << BANK_W)-1:0] open_valid_q;

   function automatic logic [ADDR_W-1:0] with_bit(input logic [ADDR_W-1:0] v,
                                                   input int pos, input logic b);
      logic [ADDR_W-1:0] r;
      r = v;
      r[pos] = b;
      return r;
   endfunction

   function automatic logic [ADDR_W-1:0] ext1_word(input logic [2:0] drv);
      logic [ADDR_W-1:0] r;
      r = with_bit(EXT1_OPS, `DDRI_ADDR_DLL_OFF, 1'b0);
      r[`DDRI_ADDR_DRV_MSB:`DDRI_ADDR_DRV_LSB] = drv;
      r[ADDR_W-1:13] = '0;
      return r;
   endfunction

   ddri_wait_timer #(.WIDTH(32)) u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .load(timer_load),
      .value(timer_val),
      .done(timer_done)
   );

   // Steps after the clock-enable wait issue a command when the spacing timer runs out; refresh sends two, calibration also waits on the lock count.
   assign issue = timer_done && (state_q != DDRI_S_READY) && (state_q != DDRI_S_POWER)
                  && (state_q != DDRI_S_CKE);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= DDRI_S_POWER;
      end
      else
      begin
         unique case (state_q)
            DDRI_S_POWER: if (started_q && timer_done) state_q <= DDRI_S_CKE;
            DDRI_S_CKE: if (timer_done) state_q <= DDRI_S_PRE1;
            DDRI_S_PRE1: if (issue) state_q <= DDRI_S_EMR2;
            DDRI_S_EMR2: if (issue) state_q <= DDRI_S_EMR3;
            DDRI_S_EMR3: if (issue) state_q <= DDRI_S_EMR1;
            DDRI_S_EMR1: if (issue) state_q <= DDRI_S_MRRST;
            DDRI_S_MRRST: if (issue) state_q <= DDRI_S_PRE2;
            DDRI_S_PRE2: if (issue) state_q <= DDRI_S_REF;
            DDRI_S_REF: if (issue && ref_cnt_q == 2'(`DDRI_REFRESH_COUNT - 1))
               state_q <= DDRI_S_MROP;
            DDRI_S_MROP: if (issue) state_q <= DDRI_S_DRVDEF;
            DDRI_S_DRVDEF: if (issue && lock_cnt_q == '0) state_q <= DDRI_S_DRVEXIT;
            DDRI_S_DRVEXIT: if (issue) state_q <= DDRI_S_READY;
            DDRI_S_READY: state_q <= DDRI_S_READY;
         endcase
      end
   end

   // The spacing timer is reloaded whenever a step issues, but not on entry to DDRI_S_PRE1; the gap
   // also covers mode-write and precharge recovery with margin.
   always_comb
   begin
      timer_load = 1'b0;
      timer_val = 32'(`DDRI_GAP_CYC);
      if (state_q == DDRI_S_POWER && !started_q)
      begin
         timer_load = 1'b1;
         timer_val = 32'(T_STABLE_CYC);
      end
      else if (state_q == DDRI_S_POWER && timer_done)
      begin
         timer_load = 1'b1;
         timer_val = 32'(`DDRI_T_CKE_CYC);
      end
      else if (issue)
      begin
         timer_load = 1'b1;
      end
   end

   // Power-on wait: loaded once after reset release.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         started_q <= 1'b0;
      end
      else
      begin
         started_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ref_cnt_q <= '0;
      end
      else if (state_q == DDRI_S_REF && issue)
      begin
         ref_cnt_q <= ref_cnt_q + 2'h1;
      end
   end

   // Counts clocks since the loop-reset write before calibration may start.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lock_cnt_q <= 8'hFF;
      end
      else if (state_q == DDRI_S_MRRST && issue)
      begin
         lock_cnt_q <= 8'(`DDRI_DLL_LOCK_CYC - 1);
      end
      else if (lock_cnt_q != '0 && state_q > DDRI_S_MRRST)
      begin
         lock_cnt_q <= lock_cnt_q - 8'h1;
      end
   end

   // ------------------------------------------------------------------
   // Command selection
   // ------------------------------------------------------------------
   always_comb
   begin
      cmd_d = `DDRI_CMD_NOP;
      bank_d = '0;
      addr_d = '0;
      if (issue)
      begin
         unique case (state_q)
            DDRI_S_PRE1, DDRI_S_PRE2:
            begin
               cmd_d = `DDRI_CMD_PRE;
               addr_d = with_bit('0, `DDRI_ADDR_AUTO_PRE, 1'b1);
            end
            DDRI_S_EMR2:
            begin
               cmd_d = `DDRI_CMD_MODE;
               bank_d = `DDRI_BANK_EMR2;
            end
            DDRI_S_EMR3:
            begin
               cmd_d = `DDRI_CMD_MODE;
               bank_d = `DDRI_BANK_EMR3;
            end
            DDRI_S_EMR1:
            begin
               cmd_d = `DDRI_CMD_MODE;
               bank_d = `DDRI_BANK_EMR1;
               addr_d = ext1_word(3'h0);
            end
            DDRI_S_MRRST:
            begin
               cmd_d = `DDRI_CMD_MODE;
               bank_d = `DDRI_BANK_MR;
               addr_d = with_bit(MODE_OPS & 16'h1FFF, `DDRI_ADDR_DLL_RESET, 1'b1);
            end
            DDRI_S_REF: cmd_d = `DDRI_CMD_REF;
            DDRI_S_MROP:
            begin
               cmd_d = `DDRI_CMD_MODE;
               bank_d = `DDRI_BANK_MR;
               addr_d = with_bit(MODE_OPS & 16'h1FFF, `DDRI_ADDR_DLL_RESET, 1'b0);
            end
            DDRI_S_DRVDEF:
            begin
               cmd_d = (lock_cnt_q == '0) ? `DDRI_CMD_MODE : `DDRI_CMD_NOP;
               bank_d = `DDRI_BANK_EMR1;
               addr_d = ext1_word(3'h7);
            end
            DDRI_S_DRVEXIT:
            begin
               cmd_d = `DDRI_CMD_MODE;
               bank_d = `DDRI_BANK_EMR1;
               addr_d = ext1_word(3'h0);
            end
            default: cmd_d = `DDRI_CMD_NOP;
         endcase
      end
      else if (state_q == DDRI_S_READY && req_valid)
      begin
         bank_d = req_bank;
         addr_d = req_addr;
         unique case (req_op)
            DDRI_OP_ACT: cmd_d = `DDRI_CMD_ACT;
            DDRI_OP_RD, DDRI_OP_WR:
            begin
               // Column orders to a closed bank are not passed on.
               cmd_d = !open_valid_q[req_bank] ? `DDRI_CMD_NOP
                     : (req_op == DDRI_OP_RD) ? `DDRI_CMD_RD : `DDRI_CMD_WR;
               addr_d = with_bit(req_addr, `DDRI_ADDR_AUTO_PRE, req_auto_pre);
            end
            DDRI_OP_PRE:
            begin
               cmd_d = `DDRI_CMD_PRE;
               addr_d = with_bit('0, `DDRI_ADDR_AUTO_PRE, req_auto_pre);
            end
         endcase
      end
   end

   assign req_ready = (state_q == DDRI_S_READY);

   // Tracks which banks hold an open row, so no read or write is sent to a
   // closed bank. One bit stands for each bank.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         open_valid_q <= '0;
      end
      else if (state_q == DDRI_S_READY && req_valid)
      begin
         if (req_op == DDRI_OP_ACT)
         begin
            open_valid_q[req_bank] <= 1'b1;
         end
         else if (req_op == DDRI_OP_PRE)
         begin
            if (req_auto_pre)
            begin
               open_valid_q <= '0;
            end
            else
            begin
               open_valid_q[req_bank] <= 1'b0;
            end
         end
         else if (req_auto_pre && open_valid_q[req_bank])
         begin
            open_valid_q[req_bank] <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Pin registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_q <= `DDRI_CMD_NOP;
         bank_q <= '0;
         mem_addr <= '0;
      end
      else
      begin
         cmd_q <= cmd_d;
         bank_q <= bank_d;
         mem_addr <= addr_d;
      end
   end

   // Clock enable stays low until the power-on wait ends, then high for good.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_ck_en <= 1'b0;
      end
      else if (state_q != DDRI_S_POWER)
      begin
         mem_ck_en <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         init_done <= 1'b0;
      end
      else
      begin
         init_done <= (state_q == DDRI_S_READY);
      end
   end

   // Termination is never enabled by this controller.
   assign die_term_ctl = 1'b0;
   assign mem_cs_n = cmd_q[3];
   assign mem_ras_n = cmd_q[2];
   assign mem_cas_n = cmd_q[1];
   assign mem_we_n = cmd_q[0];
   assign bank_sel_0 = bank_q[0];
   assign bank_sel_1 = bank_q[1];
   assign bank_sel_2 = bank_q[2];

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   logic [31:0] cke_age_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cke_age_q <= '0;
      end
      else if (mem_ck_en && cke_age_q != 32'hFFFFFFFF)
      begin
         cke_age_q <= cke_age_q + 32'h1;
      end
   end

   a_cke_low_boot: assert property (@(posedge clk) disable iff (!rst_n)
      (!started_q || state_q == DDRI_S_POWER) |-> !mem_ck_en)
      else $error("clock enable high at start");
   a_term_off: assert property (@(posedge clk) disable iff (!rst_n)
      !die_term_ctl) else $error("termination driven high");
   a_nop_after_cke: assert property (@(posedge clk) disable iff (!rst_n)
      (mem_ck_en && cke_age_q < 32'(`DDRI_T_CKE_CYC)) |-> (cmd_q == `DDRI_CMD_NOP))
      else $error("command too soon after clock enable");
   a_emr2_bank: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == DDRI_S_EMR2 && issue) |=> (cmd_q == `DDRI_CMD_MODE && bank_q == 3'h2))
      else $error("bad second extended write");
   a_emr3_bank: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == DDRI_S_EMR3 && issue) |=> (bank_q == 3'h3)) else $error("bad third write");
   a_dll_reset_bit: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == DDRI_S_MRRST && issue) |=> (mem_addr[8] && mem_addr[15:13] == 3'h0))
      else $error("loop reset bit missing");
   a_mrop_bit: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == DDRI_S_MROP && issue) |=> (!mem_addr[8] && bank_q == 3'h0))
      else $error("operating write resets loop");
   a_lock_wait: assert property (@(posedge clk) disable iff (!rst_n)
      (cmd_q == `DDRI_CMD_MODE && bank_q == 3'h1 && mem_addr[9:7] == 3'h7)
      |-> ($past(state_q, 200) > DDRI_S_MRRST)) else $error("calibration too early");
   a_pre_all: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == DDRI_S_PRE2 && issue) |=> (cmd_q == `DDRI_CMD_PRE && mem_addr[10]))
      else $error("precharge all malformed");
   c_init_done: cover property (@(posedge clk) disable iff (!rst_n) $rose(init_done));
   c_activate: cover property (@(posedge clk) disable iff (!rst_n) cmd_q == `DDRI_CMD_ACT);
   c_read: cover property (@(posedge clk) disable iff (!rst_n) cmd_q == `DDRI_CMD_RD);
endmodule

// File: src/ddri_wait_timer.sv
/*
 Down-counting wait timer used to space the initialization commands.
 Assumes a single clock domain; load and count come from the same clock.
*/
`timescale 1ns/100ps
module ddri_wait_timer
   import ddri_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [WIDTH-1:0] value,
   output logic done
);
   logic [WIDTH-1:0] count_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_q <= '0;
      end
      else if (load)
      begin
         count_q <= value;
      end
      else if (count_q != '0)
      begin
         count_q <= count_q - 1'b1;
      end
   end

   // Done does not look at load: the caller builds load from done, and
   // folding load back in here would close a combinational loop.
   assign done = (count_q == '0);
endmodule

// File: verif/ddri_mem_model.sv
/*
 Behavioural model of the memory device on the far side of the sequencer.
 Assumes commands are sampled on the rising edge of the controller clock.
*/
`timescale 1ns/100ps
`include "ddri_params.svh"
module ddri_mem_model
(
   input wire logic clk,
   input wire logic ck_en,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] bank,
   input wire logic [15:0] addr,
   output logic strobe_diff,
   output logic rd_strobe_en,
   output logic [7:0] open_q,
   output logic [15:0] col_q,
   output logic [3:0] beats_q,
   output logic [7:0] bad_q
);
   logic [3:0] cmd;
   logic [3:0] bl_q;
   logic [3:0] left_q;
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   initial
   begin
      open_q = 8'h00;
      bad_q = 8'h00;
      left_q = 4'h0;
      beats_q = 4'h0;
      bl_q = 4'h4;
   end
   // One beat is counted per clock; the data bus itself is not modelled.
   always @(posedge clk)
   begin
      if (left_q != 4'h0)
      begin
         left_q <= left_q - 4'h1;
         beats_q <= beats_q + 4'h1;
      end
      if (ck_en && !cs_n)
      begin
         case (cmd)
            `DDRI_CMD_MODE:
            begin
               if (bank == 3'h0)
                  bl_q <= (addr[2:0] == 3'h3) ? 4'h8 : 4'h4;
               if (bank == 3'h1)
               begin
                  strobe_diff <= !addr[10];
                  rd_strobe_en <= addr[11];
               end
            end
            `DDRI_CMD_ACT: open_q[bank] <= 1'b1;
            `DDRI_CMD_PRE:
            begin
               if (addr[10])
                  open_q <= 8'h00;
               else
                  open_q[bank] <= 1'b0;
            end
            `DDRI_CMD_RD, `DDRI_CMD_WR:
            begin
               if (!open_q[bank])
                  bad_q <= bad_q + 8'h1;
               else
               begin
                  col_q <= addr;
                  left_q <= bl_q;
                  beats_q <= 4'h0;
                  if (addr[10])
                     open_q[bank] <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end
endmodule

// File: verif/tb_top.sv
/*
 Self-checking bench for the power-up sequencer and its order port.
 Assumes the memory model stands on the command pins and the clock is 100 MHz.
*/
`timescale 1ns/100ps
`include "ddri_params.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
   $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module tb_top
   import ddri_pkg::*;
;
   localparam int T_ST = 10;
   localparam logic [15:0] MODE = 16'h0032;
   localparam logic [15:0] EXT1 = 16'h0800;
   typedef struct {ddri_op_t op; logic [2:0] b; logic [15:0] a; logic ap;
      logic [3:0] c; logic [15:0] ea; logic [7:0] eo;} ddri_row_t;
   logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_ready, req_auto_pre = 1'b0;
   ddri_op_t req_op = DDRI_OP_ACT;
   logic [2:0] req_bank = 3'h0;
   logic [15:0] req_addr = 16'h0000;
   logic init_done, mem_ck_en, die_term_ctl, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
   logic bank_sel_0, bank_sel_1, bank_sel_2, strobe_diff, rd_strobe_en;
   logic [15:0] mem_addr, col_q;
   logic [7:0] open_q, bad_q;
   logic [3:0] beats_q;
   logic [3:0] lc[$];
   logic [2:0] lb[$];
   logic [15:0] la[$];
   int lt[$];
   int n_fail = 0, checked = 0, cyc = 1, ck_rise = 0, rel_cyc = 0, odt_bad = 0, cke_bad = 0;
   logic [3:0] ic[11] = '{`DDRI_CMD_PRE, `DDRI_CMD_MODE, `DDRI_CMD_MODE, `DDRI_CMD_MODE,
      `DDRI_CMD_MODE, `DDRI_CMD_PRE, `DDRI_CMD_REF, `DDRI_CMD_REF, `DDRI_CMD_MODE,
      `DDRI_CMD_MODE, `DDRI_CMD_MODE};
   logic [2:0] ib[11] = '{3'h0, 3'h2, 3'h3, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1};
   logic ibm[11] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
   logic [15:0] im[11] = '{16'h0400, 16'h0000, 16'h0000, 16'hEF81, 16'hE100, 16'h0400,
      16'h0000, 16'h0000, 16'hE100, 16'h0F80, 16'h0F80};
   logic [15:0] iv[11] = '{16'h0400, 16'h0000, 16'h0000, EXT1 & 16'h0C00, 16'h0100, 16'h0400,
      16'h0000, 16'h0000, 16'h0000, (EXT1 & 16'h0C00) | 16'h0380, EXT1 & 16'h0C00};
   ddri_row_t rows[8] = '{
      '{DDRI_OP_ACT, 3'h1, 16'h1234, 1'b0, `DDRI_CMD_ACT, 16'h1234, 8'h02},
      '{DDRI_OP_ACT, 3'h5, 16'h0ABC, 1'b0, `DDRI_CMD_ACT, 16'h0ABC, 8'h22},
      '{DDRI_OP_RD, 3'h1, 16'h0040, 1'b0, `DDRI_CMD_RD, 16'h0040, 8'h22},
      '{DDRI_OP_WR, 3'h5, 16'h0048, 1'b1, `DDRI_CMD_WR, 16'h0448, 8'h02},
      '{DDRI_OP_RD, 3'h5, 16'h0010, 1'b0, `DDRI_CMD_NOP, 16'h0000, 8'h02},
      '{DDRI_OP_PRE, 3'h1, 16'h0000, 1'b0, `DDRI_CMD_PRE, 16'h0000, 8'h00},
      '{DDRI_OP_ACT, 3'h3, 16'h7FFF, 1'b0, `DDRI_CMD_ACT, 16'h7FFF, 8'h08},
      '{DDRI_OP_PRE, 3'h0, 16'h0000, 1'b1, `DDRI_CMD_PRE, 16'h0400, 8'h00}};

   // ----------------------------------------------------------------
   // Clock, design, model and command monitor
   // ----------------------------------------------------------------
   always #5 clk = ~clk;
   ddri_init_ctrl #(.T_STABLE_CYC(T_ST), .MODE_OPS(MODE), .EXT1_OPS(EXT1)) i_dut (.clk(clk),
      .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
      .req_bank(req_bank), .req_addr(req_addr), .req_auto_pre(req_auto_pre),
      .init_done(init_done), .mem_ck_en(mem_ck_en), .die_term_ctl(die_term_ctl),
      .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
      .bank_sel_0(bank_sel_0), .bank_sel_1(bank_sel_1), .bank_sel_2(bank_sel_2),
      .mem_addr(mem_addr));
   ddri_mem_model i_mem (.clk(clk), .ck_en(mem_ck_en), .cs_n(mem_cs_n), .ras_n(mem_ras_n),
      .cas_n(mem_cas_n), .we_n(mem_we_n), .bank({bank_sel_2, bank_sel_1, bank_sel_0}),
      .addr(mem_addr), .strobe_diff(strobe_diff), .rd_strobe_en(rd_strobe_en),
      .open_q(open_q), .col_q(col_q), .beats_q(beats_q), .bad_q(bad_q));
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (die_term_ctl !== 1'b0)
         odt_bad <= odt_bad + 1;
      if (rst_n && ck_rise != 0 && mem_ck_en !== 1'b1)
         cke_bad <= cke_bad + 1;
      if (rst_n && mem_ck_en === 1'b1 && ck_rise == 0)
         ck_rise <= cyc;
      if (rst_n && {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} !== `DDRI_CMD_NOP)
      begin
         lc.push_back({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n});
         lb.push_back({bank_sel_2, bank_sel_1, bank_sel_0});
         la.push_back(mem_addr);
         lt.push_back(cyc);
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      `CHK("ck_en_rst", 1'b0, mem_ck_en)
      `CHK("term_rst", 1'b0, die_term_ctl)
      `CHK("cmd_rst", `DDRI_CMD_NOP, {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n})
      `CHK("ready_rst", 2'b00, {req_ready, init_done})
      lc.delete();
      lb.delete();
      la.delete();
      lt.delete();
      ck_rise = 0;
      rst_n <= 1'b1;
      rel_cyc = cyc;
   endtask
   task automatic check_init(input bit exact);
      int k;
      for (k = 0; k < 3000 && init_done !== 1'b1; k++)
         @(posedge clk);
      if (init_done !== 1'b1)
      begin
         n_fail++;
         end_sim();
      end
      if (exact)
         `CHK("init_count", 11, lc.size())
      for (k = 0; k < 11; k++)
      begin
         `CHK("init_cmd", ic[k], lc[k])
         if (ibm[k])
            `CHK("init_bank", ib[k], lb[k])
         `CHK("init_addr", iv[k], la[k] & im[k])
      end
      `CHK("cke_wait", 1'b1, ck_rise - rel_cyc >= T_ST)
      `CHK("nop_gap", 1'b1, lt[0] - ck_rise >= 40)
      `CHK("cal_gap", 1'b1, lt[9] - lt[4] >= 200)
      `CHK("strobe_mode", {!EXT1[10], EXT1[11]}, {strobe_diff, rd_strobe_en})
      $display("test init done");
   endtask
   task automatic order(input ddri_op_t op, input logic [2:0] b, input logic [15:0] a,
      input logic ap);
      @(posedge clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_bank <= b;
      req_addr <= a;
      req_auto_pre <= ap;
      @(posedge clk);
      req_valid <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      int n0;
      int k;
      do_reset();
      check_init(1'b1);
      foreach (rows[i])
      begin
         n0 = lc.size();
         order(rows[i].op, rows[i].b, rows[i].a, rows[i].ap);
         repeat (10) @(posedge clk);
         if (rows[i].c === `DDRI_CMD_NOP)
            `CHK("refused", n0, lc.size())
         else
         begin
            `CHK("row_cmd", rows[i].c, lc[n0])
            `CHK("row_bank", rows[i].b, lb[n0])
            `CHK("row_addr", rows[i].ea, la[n0])
            if (rows[i].op == DDRI_OP_RD || rows[i].op == DDRI_OP_WR)
               `CHK("burst", {rows[i].ea, 4'h4}, {col_q, beats_q})
         end
         `CHK("open_rows", rows[i].eo, open_q)
      end
      `CHK("bad_access", 8'h00, bad_q)
      $display("test rows done");
      n0 = lc.size();
      order(DDRI_OP_ACT, 3'h2, 16'h0101, 1'b0);
      order(DDRI_OP_RD, 3'h2, 16'h0008, 1'b0);
      repeat (10) @(posedge clk);
      `CHK("b2b_count", n0 + 2, lc.size())
      `CHK("b2b_cmds", {`DDRI_CMD_ACT, `DDRI_CMD_RD}, {lc[n0], lc[n0 + 1]})
      `CHK("b2b_col", 16'h0008, col_q)
      $display("test back_to_back done");
      do_reset();
      @(posedge clk);
      req_op <= DDRI_OP_ACT;
      req_bank <= 3'h4;
      req_addr <= 16'h0044;
      req_valid <= 1'b1;
      for (k = 0; k < 3000 && init_done !== 1'b1; k++)
         @(posedge clk);
      req_valid <= 1'b0;
      check_init(1'b0);
      repeat (3) @(posedge clk);
      `CHK("held_order", {`DDRI_CMD_ACT, 3'h4}, {lc[11], lb[11]})
      `CHK("term_low", 0, odt_bad)
      `CHK("cke_steady", 0, cke_bad)
      $display("test reinit done");
      end_sim();
   end
endmodule
